//--- thf_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/10ps
module thf_fifo #(
   parameter int WIDTH = thf_pkg::FIFO_WIDTH,
   parameter int DEPTH = thf_pkg::FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic flush,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [PW:0] count;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
   } thf_fifo_t;
   thf_fifo_t regs, next_regs;
   logic [WIDTH-1:0] store [DEPTH];
   logic push, pop;

   assign wr_ready = regs.count != (PW+1)'(DEPTH);
   assign rd_valid = regs.count != '0;
   assign rd_data = store[regs.rptr];
   assign push = wr_valid & wr_ready & ~flush;
   assign pop = rd_ready & rd_valid & ~flush;

   always_comb begin
      next_regs = regs;
      if (flush) begin
         next_regs = '0;
      end else begin
         if (push) begin
            next_regs.wptr = regs.wptr + 1'b1;
         end
         if (pop) begin
            next_regs.rptr = regs.rptr + 1'b1;
         end
         next_regs.count = regs.count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         regs <= '0;
      end else begin
         regs <= next_regs;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         store[regs.wptr] <= wr_data;
      end
   end
endmodule

//--- thf_pkg.sv
// Constants for the transmit HDLC frame controller.
// Assumes a 250 MHz clock and register indexes as word addresses.
package thf_pkg;
   localparam logic [13:0] IDX_CFG = 14'h010f;
   localparam logic [13:0] IDX_CTRL1 = 14'h0110;
   localparam logic [13:0] IDX_SUPP = 14'h0111;
   localparam logic [13:0] IDX_DATA = 14'h0112;
   localparam logic [13:0] IDX_CTRL2 = 14'h0113;
   localparam logic [13:0] IDX_BOC = 14'h0115;
   localparam logic [13:0] IDX_STAT = 14'h0116;
   localparam int PORT_STRIDE = 32'h00000200;
   localparam int C1_FLAG_CNT = 7;
   localparam int C1_LOOP = 6;
   localparam int C1_RST = 5;
   localparam int C1_MAP = 4;
   localparam int C1_FILL = 3;
   localparam int C1_EOM = 2;
   localparam int C1_ZSD = 1;
   localparam int C1_CRCD = 0;
   localparam int C2_ABT = 7;
   localparam int C2_BOC = 6;
   localparam int C2_EN = 5;
   localparam int CFG_T1 = 0;
   localparam int CFG_FDL = 1;
   localparam int ENT_EOM = 8;
   localparam int ENT_LOOP = 9;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] FLAG_BYTE = 8'h7e;
   localparam logic [7:0] IDLE_BYTE = 8'hff;
   localparam logic [7:0] ABORT_BYTE = 8'hfe;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam int CLK_MHZ = 250;
   localparam int SRST_LIMIT_NS = 250000;
   localparam logic [3:0] SRST_LAST = 4'h7;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_WIDTH = 10;
   localparam int LOOP_DEPTH = 64;
   typedef enum logic [5:0] {
      ST_FILL = 6'h01,
      ST_FLAG = 6'h02,
      ST_DATA = 6'h04,
      ST_CRC = 6'h08,
      ST_ABORT = 6'h10,
      ST_RESET = 6'h20
   } thf_st_t;
endpackage

//--- thf_slot_model.sv
// Framer side of one port: offers a channel-0 slot every cycle.
// Assumes each carried slot is answered one cycle later; counts the
// first sixteen bits returned after clr.
`timescale 1ns/10ps
module thf_slot_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic clr,
   input wire logic tx_bit,
   input wire logic tx_bit_valid,
   output logic slot_strobe,
   output logic [4:0] slot_channel,
   output logic [2:0] slot_bit_pos,
   output logic slot_is_fdl,
   output logic [4:0] nvalid,
   output logic [4:0] nones
);
   assign slot_channel = 5'h00;
   assign slot_is_fdl = 1'b0;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         slot_strobe <= 1'b0;
         slot_bit_pos <= 3'h7;
         nvalid <= 5'h00;
         nones <= 5'h00;
      end else begin
         slot_strobe <= 1'b1;
         slot_bit_pos <= slot_bit_pos - 3'h1;
         if (clr) begin
            nvalid <= 5'h00;
            nones <= 5'h00;
         end else if (tx_bit_valid && nvalid < 5'h10) begin
            nvalid <= nvalid + 5'h01;
            nones <= nones + {4'h0, tx_bit};
         end
      end
   end
endmodule

//--- thf_tx_hdlc.sv
// Transmit HDLC frame controller for one framer port, APB slave.
// Assumes slot requests come from framer logic on the same clock.
// Contract
// - One closing flag between messages, or two when flag count set.
// - Loop bit before last byte makes that message repeat.
// - Clearing loop bit: finish looping message, then flags until new data; the code sends the fill byte, FFh when fill select is set.
// - New message during loop ends it, flags, then new message.
// - Soft reset flushes FIFO, then abort and fill until new data.
// - Soft reset bit clears itself; reset takes under 250 us.
// - Mapping bit picks DS0 channel or FDL/Sa bits with enable.
// - Fill between messages is 7Eh or FFh per fill select.
// - End-of-message before last byte closes message with CRC.
// - Insert zero after five ones unless stuffer defeated.
// - Append two-byte CRC unless CRC defeat is set.
// - Each suppress bit removes one channel bit position from use.
// - Abort rising edge flushes FIFO, sends FEh, then fill.
// - In T1 mode send-BOC bit transmits six-bit BOC code.
// - Controller transmits only while its enable bit is one; BOC bits go out regardless of it.
// - Channel select takes effect only at controller reset.
`timescale 1ns/10ps
module thf_tx_hdlc #(
   parameter int PORT_NUM = 1,
   parameter int LOOP_DEPTH = thf_pkg::LOOP_DEPTH,
   parameter int SRST_LIMIT_CYC =
      thf_pkg::SRST_LIMIT_NS * thf_pkg::CLK_MHZ / 1000
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slot_strobe,
   input wire logic [4:0] slot_channel,
   input wire logic [2:0] slot_bit_pos,
   input wire logic slot_is_fdl,
   output logic tx_bit,
   output logic tx_bit_valid
);
   localparam int AW = $clog2(LOOP_DEPTH);
   localparam logic [13:0] BASE =
      14'(thf_pkg::PORT_STRIDE * (PORT_NUM - 1));

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] suppress;
      logic [7:0] ctrl2;
      logic [5:0] boc;
      logic [1:0] cfg;
      logic abort_prev;
      thf_pkg::thf_st_t st;
      logic [7:0] shreg;
      logic [3:0] cnt;
      logic [2:0] ones;
      logic [15:0] crc;
      logic [1:0] flags_left;
      logic last;
      logic loop_armed;
      logic replay;
      logic [AW:0] wr_idx;
      logic [AW:0] rd_idx;
      logic [AW:0] loop_len;
      logic [4:0] active_chan;
      logic [3:0] rst_cnt;
      logic [3:0] boc_cnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic tx_bit;
      logic tx_valid;
   } thf_regs_t;

   thf_regs_t regs, next_regs;
   logic [7:0] loop_mem [LOOP_DEPTH];
   logic mem_we;
   logic [AW-1:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic fifo_flush, fifo_wr_valid, fifo_wr_ready;
   logic fifo_rd_valid, fifo_rd_ready;
   logic [9:0] fifo_rd_data;
   logic [13:0] idx;
   logic sel_cfg, sel_c1, sel_supp, sel_data, sel_c2, sel_boc, sel_stat;
   logic mapped, acc, carried, boc_slot, adv, stuff, out_bit;
   logic abort_edge, ovr;
   logic [15:0] boc_word;
   logic [7:0] fill;
   logic [1:0] close_n;
   logic take_fifo, take_mem, first_byte;
   logic [AW:0] bidx;

   function automatic logic [15:0] crc_step(logic [15:0] c, logic b);
      logic fb;
      fb = c[0] ^ b;
      crc_step = c >> 1;
      if (fb) begin
         crc_step = crc_step ^ thf_pkg::CRC_POLY;
      end
   endfunction

   thf_fifo #(
      .WIDTH(thf_pkg::FIFO_WIDTH),
      .DEPTH(thf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .flush(fifo_flush),
      .wr_valid(fifo_wr_valid),
      .wr_ready(fifo_wr_ready),
      .wr_data({regs.ctrl1[thf_pkg::C1_LOOP],
                regs.ctrl1[thf_pkg::C1_EOM]
                | regs.ctrl1[thf_pkg::C1_LOOP], pwdata[7:0]}),
      .rd_valid(fifo_rd_valid),
      .rd_ready(fifo_rd_ready),
      .rd_data(fifo_rd_data)
   );

   assign idx = paddr[15:2] - BASE;
   assign sel_cfg = idx == thf_pkg::IDX_CFG;
   assign sel_c1 = idx == thf_pkg::IDX_CTRL1;
   assign sel_supp = idx == thf_pkg::IDX_SUPP;
   assign sel_data = idx == thf_pkg::IDX_DATA;
   assign sel_c2 = idx == thf_pkg::IDX_CTRL2;
   assign sel_boc = idx == thf_pkg::IDX_BOC;
   assign sel_stat = idx == thf_pkg::IDX_STAT;
   assign mapped = sel_cfg | sel_c1 | sel_supp | sel_data | sel_c2
                   | sel_boc | sel_stat;
   assign acc = psel & penable;

   // BOC on FDL slots in T1
   assign boc_slot = slot_strobe & slot_is_fdl
                     & regs.cfg[thf_pkg::CFG_T1]
                     & regs.ctrl2[thf_pkg::C2_BOC];
   assign boc_word = {thf_pkg::IDLE_BYTE, 1'b0, regs.boc, 1'b0};

   assign carried = slot_strobe & ~boc_slot & regs.ctrl2[thf_pkg::C2_EN]
      & (regs.ctrl1[thf_pkg::C1_MAP]
         ? slot_is_fdl & regs.cfg[thf_pkg::CFG_FDL]
         : ~slot_is_fdl & slot_channel == regs.active_chan
           & ~regs.suppress[slot_bit_pos]);
   assign adv = carried & regs.st != thf_pkg::ST_RESET;

   // Zero insertion point
   // Ones run carries into the first flag bit after data
   assign stuff = regs.ones == 3'd5 & ~regs.ctrl1[thf_pkg::C1_ZSD];
   assign out_bit = regs.st == thf_pkg::ST_CRC ? ~regs.crc[0]
                    : regs.shreg[0];
   // Only a fresh rising edge aborts
   assign abort_edge = regs.ctrl2[thf_pkg::C2_ABT] & ~regs.abort_prev;
   assign ovr = abort_edge | regs.ctrl1[thf_pkg::C1_RST]
                | regs.st == thf_pkg::ST_RESET;

   always_comb begin
      next_regs = regs;
      fifo_rd_ready = 1'b0;
      fifo_wr_valid = 1'b0;
      fifo_flush = 1'b0;
      mem_we = 1'b0;
      mem_waddr = regs.wr_idx[AW-1:0];
      mem_wdata = fifo_rd_data[7:0];
      take_fifo = 1'b0;
      take_mem = 1'b0;
      first_byte = 1'b0;
      bidx = '0;
      fill = regs.ctrl1[thf_pkg::C1_FILL] ? thf_pkg::IDLE_BYTE
             : thf_pkg::FLAG_BYTE;
      close_n = regs.ctrl1[thf_pkg::C1_FLAG_CNT] ? 2'd2 : 2'd1;
      next_regs.tx_valid = 1'b0;
      next_regs.abort_prev = regs.ctrl2[thf_pkg::C2_ABT];
      if (boc_slot) begin
         next_regs.tx_valid = 1'b1;
         next_regs.tx_bit = boc_word[regs.boc_cnt];
         next_regs.boc_cnt = regs.boc_cnt + 4'd1;
      end
      if (adv) begin
         next_regs.tx_valid = 1'b1;
         if (stuff) begin
            next_regs.tx_bit = 1'b0;
            next_regs.ones = 3'd0;
         end else begin
            next_regs.tx_bit = out_bit;
            next_regs.ones = 3'd0;
            if (regs.st == thf_pkg::ST_DATA
                || regs.st == thf_pkg::ST_CRC) begin
               next_regs.ones = out_bit ? regs.ones + 3'd1 : 3'd0;
            end
            if (regs.st == thf_pkg::ST_DATA) begin
               next_regs.crc = crc_step(regs.crc, regs.shreg[0]);
            end
            if (regs.st == thf_pkg::ST_CRC) begin
               next_regs.crc = regs.crc >> 1;
            end
            next_regs.shreg = regs.shreg >> 1;
            next_regs.cnt = regs.cnt + 4'd1;
            if (regs.st == thf_pkg::ST_CRC ? regs.cnt == 4'hf
                : regs.cnt == 4'h7) begin
               next_regs.cnt = 4'h0;
               case (regs.st)
                  thf_pkg::ST_FILL: begin
                     if (fifo_rd_valid) begin
                        next_regs.st = thf_pkg::ST_FLAG;
                        next_regs.shreg = thf_pkg::FLAG_BYTE;
                        next_regs.flags_left = 2'd1;
                     end else begin
                        next_regs.shreg = fill;
                     end
                  end
                  thf_pkg::ST_FLAG: begin
                     if (regs.flags_left > 2'd1) begin
                        next_regs.flags_left = regs.flags_left - 2'd1;
                        next_regs.shreg = thf_pkg::FLAG_BYTE;
                     end else if (fifo_rd_valid) begin
                        take_fifo = 1'b1;
                        first_byte = 1'b1;
                     end else if (regs.loop_armed
                        && regs.ctrl1[thf_pkg::C1_LOOP]) begin
                        take_mem = 1'b1;
                        first_byte = 1'b1;
                     end else begin
                        next_regs.st = thf_pkg::ST_FILL;
                        next_regs.shreg = fill;
                        next_regs.loop_armed = 1'b0;
                        next_regs.replay = 1'b0;
                     end
                  end
                  thf_pkg::ST_DATA: begin
                     if (regs.last) begin
                        if (regs.ctrl1[thf_pkg::C1_CRCD]) begin
                           next_regs.st = thf_pkg::ST_FLAG;
                           next_regs.shreg = thf_pkg::FLAG_BYTE;
                           next_regs.flags_left = close_n;
                        end else begin
                           next_regs.st = thf_pkg::ST_CRC;
                        end
                     end else if (regs.replay) begin
                        take_mem = 1'b1;
                     end else if (fifo_rd_valid) begin
                        take_fifo = 1'b1;
                     end else begin
                        next_regs.st = thf_pkg::ST_ABORT;
                        next_regs.shreg = thf_pkg::ABORT_BYTE;
                     end
                  end
                  thf_pkg::ST_CRC: begin
                     next_regs.st = thf_pkg::ST_FLAG;
                     next_regs.shreg = thf_pkg::FLAG_BYTE;
                     next_regs.flags_left = close_n;
                  end
                  default: begin
                     next_regs.st = thf_pkg::ST_FILL;
                     next_regs.shreg = fill;
                  end
               endcase
            end
         end
      end
      if (take_fifo) begin
         bidx = first_byte ? '0 : regs.wr_idx;
         fifo_rd_ready = 1'b1;
         next_regs.st = thf_pkg::ST_DATA;
         next_regs.shreg = fifo_rd_data[7:0];
         next_regs.last = fifo_rd_data[thf_pkg::ENT_EOM];
         mem_we = bidx < (AW+1)'(LOOP_DEPTH);
         mem_waddr = bidx[AW-1:0];
         next_regs.wr_idx = bidx + 1'b1;
         if (first_byte) begin
            next_regs.replay = 1'b0;
            next_regs.crc = thf_pkg::CRC_INIT;
         end
         if (fifo_rd_data[thf_pkg::ENT_EOM]) begin
            next_regs.loop_armed = fifo_rd_data[thf_pkg::ENT_LOOP]
                                   & mem_we;
            next_regs.loop_len = bidx + 1'b1;
         end
      end
      if (take_mem) begin
         bidx = first_byte ? '0 : regs.rd_idx;
         next_regs.st = thf_pkg::ST_DATA;
         next_regs.shreg = loop_mem[bidx[AW-1:0]];
         next_regs.last = bidx + 1'b1 == regs.loop_len;
         next_regs.rd_idx = bidx + 1'b1;
         if (first_byte) begin
            next_regs.replay = 1'b1;
            next_regs.crc = thf_pkg::CRC_INIT;
         end
      end
      if (abort_edge && regs.st != thf_pkg::ST_RESET) begin
         fifo_flush = 1'b1;
         next_regs.st = thf_pkg::ST_ABORT;
         next_regs.shreg = thf_pkg::ABORT_BYTE;
         next_regs.cnt = 4'h0;
         next_regs.replay = 1'b0;
         next_regs.loop_armed = 1'b0;
         next_regs.ones = 3'd0;
      end
      if (regs.st == thf_pkg::ST_RESET) begin
         fifo_flush = 1'b1;
         next_regs.rst_cnt = regs.rst_cnt + 4'd1;
         if (regs.rst_cnt == thf_pkg::SRST_LAST) begin
            next_regs.ctrl1[thf_pkg::C1_RST] = 1'b0;
            next_regs.st = thf_pkg::ST_ABORT;
            next_regs.shreg = thf_pkg::ABORT_BYTE;
            next_regs.cnt = 4'h0;
            next_regs.ones = 3'd0;
            next_regs.active_chan = regs.ctrl2[4:0];
         end
      end else if (regs.ctrl1[thf_pkg::C1_RST]) begin
         fifo_flush = 1'b1;
         next_regs.st = thf_pkg::ST_RESET;
         next_regs.rst_cnt = 4'h0;
         next_regs.replay = 1'b0;
         next_regs.loop_armed = 1'b0;
      end
      // APB answer one cycle into the access phase
      if (acc && !regs.pready) begin
         if (!(sel_data && pwrite && !fifo_wr_ready)) begin
            next_regs.pready = 1'b1;
            next_regs.pslverr = ~mapped;
            next_regs.prdata = '0;
            if (!pwrite) begin
               case (1'b1)
                  sel_cfg: next_regs.prdata[1:0] = regs.cfg;
                  sel_c1: next_regs.prdata[7:0] = regs.ctrl1;
                  sel_supp: next_regs.prdata[7:0] = regs.suppress;
                  sel_c2: next_regs.prdata[7:0] = regs.ctrl2;
                  sel_boc: next_regs.prdata[5:0] = regs.boc;
                  sel_stat: next_regs.prdata[5:0] = {
                     regs.st == thf_pkg::ST_FILL,
                     regs.st == thf_pkg::ST_RESET, regs.replay,
                     regs.loop_armed, ~fifo_wr_ready, fifo_rd_valid};
                  default: next_regs.prdata = '0;
               endcase
            end
         end
      end
      if (acc && regs.pready) begin
         next_regs.pready = 1'b0;
         next_regs.pslverr = 1'b0;
         if (pwrite) begin
            case (1'b1)
               sel_cfg: next_regs.cfg = pwdata[1:0];
               sel_c1: next_regs.ctrl1 = pwdata[7:0];
               sel_supp: next_regs.suppress = pwdata[7:0];
               sel_c2: next_regs.ctrl2 = pwdata[7:0];
               sel_boc: next_regs.boc = pwdata[5:0];
               sel_data: begin
                  fifo_wr_valid = 1'b1;
                  next_regs.ctrl1[thf_pkg::C1_EOM] = 1'b0;
               end
               default: next_regs.pslverr = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         regs <= '0;
         regs.st <= thf_pkg::ST_FILL;
         regs.shreg <= thf_pkg::FLAG_BYTE;
         regs.crc <= thf_pkg::CRC_INIT;
      end else begin
         regs <= next_regs;
      end
   end

   always_ff @(posedge clock) begin
      if (mem_we) begin
         loop_mem[mem_waddr] <= mem_wdata;
      end
   end

   assign prdata = regs.prdata;
   assign pready = regs.pready;
   assign pslverr = regs.pslverr;
   assign tx_bit = regs.tx_bit;
   assign tx_bit_valid = regs.tx_valid;

   int busy_cnt;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= regs.ctrl1[thf_pkg::C1_RST] ? busy_cnt + 1 : 0;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   a_en_gate: assert property (
      !regs.ctrl2[thf_pkg::C2_EN] && !boc_slot |=> !tx_bit_valid)
      else $error("bit sent while disabled");
   a_supp_mask: assert property (
      slot_strobe && !slot_is_fdl && !regs.ctrl1[thf_pkg::C1_MAP]
      && regs.suppress[slot_bit_pos] |=> !tx_bit_valid)
      else $error("suppressed bit used");
   a_fdl_route: assert property (
      slot_strobe && slot_is_fdl && !boc_slot
      && !regs.ctrl1[thf_pkg::C1_MAP] |=> !tx_bit_valid)
      else $error("fdl slot used in channel mode");
   a_chan_select: assert property (
      slot_strobe && !slot_is_fdl && slot_channel != regs.active_chan
      |=> !tx_bit_valid)
      else $error("wrong channel carried data");
   a_reset_done: assert property (
      $rose(regs.st == thf_pkg::ST_RESET) |-> ##8
      (regs.st == thf_pkg::ST_ABORT
       && regs.shreg == thf_pkg::ABORT_BYTE && fifo_rd_valid == 1'b0))
      else $error("soft reset did not end in abort");
   a_reset_bound: assert property (
      busy_cnt < SRST_LIMIT_CYC)
      else $error("soft reset took too long");
   a_abort_edge: assert property (
      abort_edge && regs.st != thf_pkg::ST_RESET
      && !regs.ctrl1[thf_pkg::C1_RST] |=>
      regs.st == thf_pkg::ST_ABORT && regs.shreg == thf_pkg::ABORT_BYTE
      && regs.cnt == 4'h0 && !fifo_rd_valid)
      else $error("abort edge not handled");
   a_zero_stuff: assert property (
      adv && stuff |=> tx_bit_valid && !tx_bit)
      else $error("zero not inserted");
   a_fill_char: assert property (
      adv && !stuff && !ovr && regs.st == thf_pkg::ST_FILL
      && regs.cnt == 4'h7 && !fifo_rd_valid |=>
      regs.shreg == ($past(regs.ctrl1[thf_pkg::C1_FILL])
                     ? thf_pkg::IDLE_BYTE : thf_pkg::FLAG_BYTE))
      else $error("wrong fill character");
   a_crc_follow: assert property (
      adv && !stuff && !ovr && regs.st == thf_pkg::ST_DATA && regs.last
      && regs.cnt == 4'h7 |=> regs.st ==
      ($past(regs.ctrl1[thf_pkg::C1_CRCD]) ? thf_pkg::ST_FLAG
       : thf_pkg::ST_CRC))
      else $error("crc not appended as set");
   a_close_flags: assert property (
      adv && !stuff && !ovr && regs.st == thf_pkg::ST_CRC
      && regs.cnt == 4'hf |=> regs.st == thf_pkg::ST_FLAG
      && regs.flags_left == ($past(regs.ctrl1[thf_pkg::C1_FLAG_CNT])
                             ? 2'd2 : 2'd1))
      else $error("wrong closing flag count");

   c_loop_replay: cover property (
      $rose(regs.replay));
   c_crc_sent: cover property (
      regs.st == thf_pkg::ST_CRC && regs.cnt == 4'hf && adv);
   c_fifo_stall: cover property (
      acc && sel_data && pwrite && !fifo_wr_ready);
   c_abort: cover property (
      abort_edge);
endmodule

//--- tx_hdlc_frame_controller_bench.sv
// Bench for the transmit HDLC controller: APB master and slot model.
// Assumes port 1 and byte address four times the register index.
`timescale 1ns/10ps
module tx_hdlc_frame_controller_bench;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, clr, se;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic slot_strobe, slot_is_fdl, tx_bit, tx_bit_valid;
   logic [4:0] slot_channel, nvalid, nones;
   logic [2:0] slot_bit_pos;
   logic [13:0] regs [3] = '{thf_pkg::IDX_CTRL1, thf_pkg::IDX_SUPP,
      thf_pkg::IDX_CTRL2};
   int err_total = 0, num_checks = 0;
   thf_tx_hdlc dut (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slot_strobe(slot_strobe), .slot_channel(slot_channel),
      .slot_bit_pos(slot_bit_pos), .slot_is_fdl(slot_is_fdl),
      .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid));
   thf_slot_model far (.clock(clock), .rst(rst), .clr(clr),
      .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
      .slot_strobe(slot_strobe), .slot_channel(slot_channel),
      .slot_bit_pos(slot_bit_pos), .slot_is_fdl(slot_is_fdl),
      .nvalid(nvalid), .nones(nones));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [13:0] idx,
         input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   // Sixteen line bits after settling: count and ones
   task automatic measure(input logic [4:0] v, input logic [4:0] o);
      repeat (20) @(posedge clock);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      repeat (40) @(posedge clock);
      chk({27'h0, nvalid}, {27'h0, v});
      chk({27'h0, nones}, {27'h0, o});
   endtask
   initial begin
      int n;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h00000000;
      clr = 1'b0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, regs[i], 8'h00);
         chk(rd, 32'h00000000);
      end
      apb(1'b0, 14'h0120, 8'h00);
      chk({31'h0, se}, 32'h00000001);
      apb(1'b1, thf_pkg::IDX_SUPP, 8'hff);
      apb(1'b0, thf_pkg::IDX_SUPP, 8'h00);
      chk(rd, 32'h000000ff);
      apb(1'b1, thf_pkg::IDX_CTRL2, 8'h20);
      measure(5'h00, 5'h00);
      apb(1'b1, thf_pkg::IDX_SUPP, 8'h00);
      measure(5'h10, 5'h0c);
      apb(1'b1, thf_pkg::IDX_CTRL2, 8'h00);
      measure(5'h00, 5'h00);
      apb(1'b1, thf_pkg::IDX_CTRL2, 8'h23);
      measure(5'h10, 5'h0c);
      apb(1'b1, thf_pkg::IDX_CTRL1, 8'h08);
      measure(5'h10, 5'h10);
      apb(1'b1, thf_pkg::IDX_CTRL1, 8'h28);
      n = 0;
      do begin
         apb(1'b0, thf_pkg::IDX_CTRL1, 8'h00);
         n++;
      end while (rd !== 32'h00000008 && n < 40);
      chk(rd, 32'h00000008);
      measure(5'h00, 5'h00);
      // Line held still: abort only on a fresh rising edge
      apb(1'b1, thf_pkg::IDX_DATA, 8'h11);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, thf_pkg::IDX_CTRL2, 8'ha3);
         apb(1'b0, thf_pkg::IDX_STAT, 8'h00);
         chk(rd, 32'h00000000);
         apb(1'b1, thf_pkg::IDX_DATA, 8'h11);
         apb(1'b1, thf_pkg::IDX_CTRL2, 8'ha3);
         apb(1'b0, thf_pkg::IDX_STAT, 8'h00);
         chk(rd, 32'h00000001);
         apb(1'b1, thf_pkg::IDX_CTRL2, 8'h23);
      end
      apb(1'b1, thf_pkg::IDX_CTRL2, 8'h20);
      apb(1'b1, thf_pkg::IDX_CTRL1, 8'h20);
      repeat (20) @(posedge clock);
      apb(1'b0, thf_pkg::IDX_CTRL1, 8'h00);
      chk(rd, 32'h00000000);
      // One-byte looped message, then loop cleared
      apb(1'b1, thf_pkg::IDX_CTRL1, 8'h40);
      apb(1'b1, thf_pkg::IDX_DATA, 8'h55);
      repeat (150) @(posedge clock);
      apb(1'b0, thf_pkg::IDX_STAT, 8'h00);
      chk(rd, 32'h0000000c);
      apb(1'b1, thf_pkg::IDX_CTRL1, 8'h00);
      repeat (150) @(posedge clock);
      apb(1'b0, thf_pkg::IDX_STAT, 8'h00);
      chk(rd, 32'h00000020);
      tally_and_finish();
   end
endmodule
